/* File: hdl/core_addr_pkg.sv */
// shared constants and types for the operand addressing unit
package core_addr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int DATA_W = 8;          // architectural byte width
    localparam int PC_W = 16;           // program counter width
    localparam int APB_AW = 8;          // apb byte address width
    localparam int APB_DW = 32;         // apb data width
    localparam int SPACE_DEPTH = 256;   // locations per address space

    ////////////////////////////////////////////////////////////////////////
    // apb register byte offsets
    localparam logic [7:0] OFF_INSTR = 8'h00;     // opcode and operand, go
    localparam logic [7:0] OFF_STATUS = 8'h04;    // busy and last opcode
    localparam logic [7:0] OFF_ACC = 8'h08;       // accumulator, read only
    localparam logic [7:0] OFF_INDEX = 8'h0C;     // index register, read only
    localparam logic [7:0] OFF_SP = 8'h10;        // stack pointer, read only
    localparam logic [7:0] OFF_PC = 8'h14;        // program counter, read only
    localparam logic [7:0] OFF_MEM_ADDR = 8'h18;  // memory window address
    localparam logic [7:0] OFF_MEM_DATA = 8'h1C;  // memory window data

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int INSTR_OPC_LSB = 0;   // opcode byte in instruction word
    localparam int INSTR_OPD_LSB = 8;   // second byte in instruction word
    localparam int MEM_SPACE_BIT = 8;   // 1 selects register space
    localparam int STATUS_BUSY_BIT = 0; // execution in progress
    localparam int STATUS_OPC_LSB = 8;  // last opcode taken
    localparam int OPC_MODE_LSB = 6;    // opcode [7:6] addressing mode
    localparam int OPC_ALU_LSB = 4;     // opcode [5:4] operation
    localparam int OPC_TGT_LSB = 2;     // opcode [3:2] register selected
    localparam int OPC_SPACE_BIT = 1;   // opcode [1] 1 = register space

    ////////////////////////////////////////////////////////////////////////
    // reset values and fixed addresses
    localparam logic [7:0] RST_BYTE = 8'h00;       // all byte registers
    localparam logic [7:0] RST_FLAGS = 8'h00;      // flag register
    localparam logic [7:0] FLAGS_REG_ADDR = 8'hF7; // flags in register space
    localparam logic [15:0] PC_STEP = 16'h0002;    // two-byte instructions

    ////////////////////////////////////////////////////////////////////////
    // encodings
    typedef enum logic [1:0] {
        MODE_SRC_IMM,
        MODE_SRC_DIR,
        MODE_SRC_IDX,
        MODE_DST_DIR
    } addr_mode_e;

    typedef enum logic [1:0] {
        ALU_MOV,
        ALU_ADD,
        ALU_AND,
        ALU_OR
    } alu_op_e;

    typedef enum logic [1:0] {
        TGT_ACC,
        TGT_INDEX,
        TGT_SP,
        TGT_FLAGS
    } target_e;

    // combine first operand a with second operand b
    function automatic logic [7:0] alu(alu_op_e op, logic [7:0] a,
                                       logic [7:0] b);
        logic [7:0] r;
        r = b;
        case (op)
            ALU_MOV: r = b;
            ALU_ADD: r = 8'(a + b);
            ALU_AND: r = a & b;
            ALU_OR: r = a | b;
            default: r = b;
        endcase
        return r;
    endfunction

endpackage

/* File: hdl/byte_store.sv */
`timescale 1ns/1ps
// flip-flop byte store: one write port, two combinational read ports
module byte_store #(
    parameter int AW = 8,
    parameter int DW = 8,
    parameter int DEPTH = 256
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [DW-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [DW-1:0] rdata_b
);

    logic [DW-1:0] mem_q [DEPTH];   // storage cells

    // write port, cells clear at reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (we && (int'(waddr) < DEPTH)) begin
            mem_q[waddr] <= wdata;
        end
    end

    // read ports, addresses beyond depth read zero
    always_comb begin
        rdata_a = '0;
        rdata_b = '0;
        if (int'(raddr_a) < DEPTH) begin
            rdata_a = mem_q[raddr_a];
        end
        if (int'(raddr_b) < DEPTH) begin
            rdata_b = mem_q[raddr_b];
        end
    end

endmodule

/* File: hdl/core_addr_unit.sv */
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - 8-bit index register, zero at reset, indexes
// - 8-bit stack pointer, zero at reset
// - 16-bit pc as high and low bytes
// - immediate second byte feeds A, F, SP, X
// - immediate to flags combines with current flags
// - direct second byte addresses source, result A/X
// - source arithmetic first operand is A or X
// - indexed source address is operand plus index
// - destination direct writes A or X to memory
// - destination arithmetic reads location, A unchanged
// - 8-bit accumulator, zero at reset, takes results
// - flags read only at register 0xF7
module core_addr_unit
    import core_addr_pkg::*;
#(
    parameter int MEM_DEPTH = SPACE_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic pready,
    output logic [APB_DW-1:0] prdata,
    output logic pslverr
);

    ////////////////////////////////////////////////////////////////////////
    // declarations
    typedef enum logic {
        ST_IDLE,
        ST_EXEC
    } exec_state_e;

    exec_state_e state_q;       // execution sequencer
    logic [7:0] acc_q;          // accumulator
    logic [7:0] index_q;        // index register
    logic [7:0] sp_q;           // stack pointer
    logic [7:0] pch_q;          // program counter high byte
    logic [7:0] pcl_q;          // program counter low byte
    logic [7:0] flags_q;        // flag register
    logic [7:0] opc_q;          // opcode under execution
    logic [7:0] opd_q;          // second instruction byte
    logic [7:0] win_addr_q;     // memory window address
    logic win_space_q;          // memory window space, 1 = register
    logic [15:0] pc_d;          // next program counter
    logic apb_setup;            // setup phase of an apb transfer
    logic apb_wr;               // write completes this edge
    logic [7:0] reg_off;        // byte offset of the access
    logic mapped;               // offset decodes to a register
    addr_mode_e mode;           // decoded addressing mode
    alu_op_e alu_op;            // decoded operation
    target_e tgt;               // decoded register select
    logic space_reg;            // decoded address space
    logic [7:0] eff_addr;       // operand address
    logic [7:0] src_reg;        // A or X as named by opcode
    logic [7:0] ram_rd_exec;    // RAM byte at operand address
    logic [7:0] reg_rd_exec;    // register space byte at operand address
    logic [7:0] mem_operand;    // selected memory operand
    logic [7:0] result;         // value to write back
    logic [7:0] tgt_cur;        // current value of immediate target
    logic exec_mem_we;          // instruction writes memory
    logic ram_we;               // RAM store write enable
    logic regs_we;              // register space store write enable
    logic [7:0] store_waddr;    // shared write address
    logic [7:0] store_wdata;    // shared write data
    logic [7:0] ram_rd_win;     // RAM byte at window address
    logic [7:0] reg_rd_win;     // register space byte at window address
    logic [7:0] win_rdata;      // window read value
    ////////////////////////////////////////////////////////////////////////
    // apb decode
    assign apb_setup = psel && !penable;
    assign apb_wr = psel && penable && pready && pwrite;
    assign reg_off = paddr;

    // offsets that answer without error
    always_comb begin
        mapped = 1'b0;
        case (reg_off)
            OFF_INSTR, OFF_STATUS, OFF_ACC, OFF_INDEX,
            OFF_SP, OFF_PC, OFF_MEM_ADDR, OFF_MEM_DATA: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction decode and operand addressing
    always_comb begin
        mode = addr_mode_e'(opc_q[OPC_MODE_LSB +: 2]);
        alu_op = alu_op_e'(opc_q[OPC_ALU_LSB +: 2]);
        tgt = target_e'(opc_q[OPC_TGT_LSB +: 2]);
        space_reg = opc_q[OPC_SPACE_BIT];
        // indexed source adds the index register, wrapping in 8 bits
        eff_addr = (mode == MODE_SRC_IDX) ? 8'(opd_q + index_q)
                    : opd_q;
        // memory modes name A or X through the low select bit
        src_reg = tgt[0] ? index_q : acc_q;
    end

    // operand fetch from the space the opcode names
    always_comb begin
        if (space_reg) begin
            // flags live at a fixed register space address
            mem_operand = (eff_addr == FLAGS_REG_ADDR) ? flags_q
                    : reg_rd_exec;
        end else begin
            mem_operand = ram_rd_exec;
        end
    end

    // current value of the immediate mode target
    always_comb begin
        case (tgt)
            TGT_ACC: tgt_cur = acc_q;
            TGT_INDEX: tgt_cur = index_q;
            TGT_SP: tgt_cur = sp_q;
            TGT_FLAGS: tgt_cur = flags_q;
            default: tgt_cur = acc_q;
        endcase
    end

    // result per addressing mode
    always_comb begin
        case (mode)
            MODE_SRC_IMM: result = alu(alu_op, tgt_cur, opd_q);
            MODE_SRC_DIR: result = alu(alu_op, src_reg, mem_operand);
            MODE_SRC_IDX: result = alu(alu_op, src_reg, mem_operand);
            MODE_DST_DIR: result = alu(alu_op, mem_operand, src_reg);
            default: result = opd_q;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // address spaces
    // destination writes skip the flag address: flags change only by AND/OR
    assign exec_mem_we = (state_q == ST_EXEC) && (mode == MODE_DST_DIR)
        && !(space_reg && (eff_addr == FLAGS_REG_ADDR));

    // write mux, instruction writeback or software window write
    always_comb begin
        ram_we = 1'b0;
        regs_we = 1'b0;
        store_waddr = win_addr_q;
        store_wdata = pwdata[7:0];
        if (exec_mem_we) begin
            // separate decode per space
            ram_we = !space_reg;
            regs_we = space_reg;
            store_waddr = eff_addr;
            store_wdata = result;
        end else if (apb_wr && (reg_off == OFF_MEM_DATA)) begin
            ram_we = !win_space_q;
            regs_we = win_space_q && (win_addr_q != FLAGS_REG_ADDR);
        end
    end

    // RAM memory space
    byte_store #(
        .AW(8),
        .DW(DATA_W),
        .DEPTH(MEM_DEPTH)
    ) u_ram_space (
        .pclk(pclk),
        .presetn(presetn),
        .we(ram_we),
        .waddr(store_waddr),
        .wdata(store_wdata),
        .raddr_a(eff_addr),
        .rdata_a(ram_rd_exec),
        .raddr_b(win_addr_q),
        .rdata_b(ram_rd_win)
    );

    // register space
    byte_store #(
        .AW(8),
        .DW(DATA_W),
        .DEPTH(SPACE_DEPTH)
    ) u_reg_space (
        .pclk(pclk),
        .presetn(presetn),
        .we(regs_we),
        .waddr(store_waddr),
        .wdata(store_wdata),
        .raddr_a(eff_addr),
        .rdata_a(reg_rd_exec),
        .raddr_b(win_addr_q),
        .rdata_b(reg_rd_win)
    );

    // window read, flags visible only at their register address
    always_comb begin
        if (win_space_q) begin
            win_rdata = (win_addr_q == FLAGS_REG_ADDR) ? flags_q
                                                       : reg_rd_win;
        end else begin
            win_rdata = ram_rd_win;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: an instruction write starts one execute cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: state_q <= (apb_wr && (reg_off == OFF_INSTR))
                                    ? ST_EXEC : ST_IDLE;
                ST_EXEC: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // instruction latch, ignored while executing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            opc_q <= RST_BYTE;
            opd_q <= RST_BYTE;
        end else if (apb_wr && (reg_off == OFF_INSTR)
                     && (state_q == ST_IDLE)) begin
            opc_q <= pwdata[INSTR_OPC_LSB +: 8];
            opd_q <= pwdata[INSTR_OPD_LSB +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // architectural registers
    // accumulator takes source mode results aimed at it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= RST_BYTE;
        end else if ((state_q == ST_EXEC) && (mode != MODE_DST_DIR)
                     && (tgt == TGT_ACC)) begin
            acc_q <= result;
        end
    end

    // index register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_q <= RST_BYTE;
        end else if ((state_q == ST_EXEC) && (mode != MODE_DST_DIR)
                     && (tgt == TGT_INDEX)) begin
            index_q <= result;
        end
    end

    // stack pointer, set only by immediate mode here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sp_q <= RST_BYTE;
        end else if ((state_q == ST_EXEC) && (mode == MODE_SRC_IMM)
                     && (tgt == TGT_SP)) begin
            sp_q <= result;
        end
    end

    // flags, changed only by immediate and/or aimed at them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q <= RST_FLAGS;
        end else if ((state_q == ST_EXEC) && (mode == MODE_SRC_IMM)
                     && (tgt == TGT_FLAGS)
                     && ((alu_op == ALU_AND) || (alu_op == ALU_OR))) begin
            flags_q <= result;
        end
    end

    // program counter steps past each two-byte instruction
    assign pc_d = 16'({pch_q, pcl_q} + PC_STEP);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pch_q <= RST_BYTE;
            pcl_q <= RST_BYTE;
        end else if (state_q == ST_EXEC) begin
            pch_q <= pc_d[15:8];
            pcl_q <= pc_d[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // memory window address register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_addr_q <= RST_BYTE;
            win_space_q <= 1'b0;
        end else if (apb_wr && (reg_off == OFF_MEM_ADDR)) begin
            win_addr_q <= pwdata[7:0];
            win_space_q <= pwdata[MEM_SPACE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb answer: ready and data registered in setup, valid in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup && !mapped;
        end
    end

    // read data captured in setup, zero for writes and unmapped offsets
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (apb_setup) begin
            prdata <= '0;
            if (!pwrite) begin
                case (reg_off)
                    OFF_INSTR: prdata <= {16'h0000, opd_q, opc_q};
                    OFF_STATUS: begin
                        prdata[STATUS_BUSY_BIT] <= (state_q == ST_EXEC);
                        prdata[STATUS_OPC_LSB +: 8] <= opc_q;
                    end
                    OFF_ACC: prdata <= {24'h000000, acc_q};
                    OFF_INDEX: prdata <= {24'h000000, index_q};
                    OFF_SP: prdata <= {24'h000000, sp_q};
                    OFF_PC: prdata <= {16'h0000, pch_q, pcl_q};
                    OFF_MEM_ADDR: prdata <= {23'h000000, win_space_q,
                                             win_addr_q};
                    OFF_MEM_DATA: prdata <= {24'h000000, win_rdata};
                    default: prdata <= '0;
                endcase
            end
        end
    end

endmodule

/* File: verification/core_addr_assertions.sv */
`timescale 1ns/1ps
// apb-side checker for the operand addressing unit
module core_addr_checker
    import core_addr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic pready,
    input wire logic [APB_DW-1:0] prdata,
    input wire logic pslverr
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // offset outside the register map
    wire logic bad = (paddr > OFF_MEM_DATA) || (paddr[1:0] != 2'b00);
    // read finishing in this cycle
    wire logic rd_end = pready && !pwrite;
    ////////////////////////////////////////////////////////////////////////
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    property p_answer;
        s_setup ##1 s_access |-> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("ready missing");
    property p_rdy_phase;
        pready |-> psel && penable;
    endproperty
    a_rdy_phase: assert property (p_rdy_phase) else $error("stray ready");
    property p_rdy_once;
        pready |=> !pready;
    endproperty
    a_rdy_once: assert property (p_rdy_once) else $error("ready too long");
    property p_err_bad;
        pready && bad |-> pslverr;
    endproperty
    a_err_bad: assert property (p_err_bad) else $error("no error");
    property p_err_ok;
        pslverr |-> pready && bad;
    endproperty
    a_err_ok: assert property (p_err_ok) else $error("false error");
    property p_bad_zero;
        rd_end && bad |-> prdata == '0;
    endproperty
    a_bad_zero: assert property (p_bad_zero) else $error("bad read data");
    property p_acc_w;
        rd_end && paddr == OFF_ACC |-> prdata[31:8] == '0;
    endproperty
    a_acc_w: assert property (p_acc_w) else $error("acc wide");
    property p_idx_w;
        rd_end && paddr == OFF_INDEX |-> prdata[31:8] == '0;
    endproperty
    a_idx_w: assert property (p_idx_w) else $error("index wide");
    property p_sp_w;
        rd_end && paddr == OFF_SP |-> prdata[31:8] == '0;
    endproperty
    a_sp_w: assert property (p_sp_w) else $error("sp wide");
    property p_pc_w;
        rd_end && paddr == OFF_PC |-> prdata[31:16] == '0;
    endproperty
    a_pc_w: assert property (p_pc_w) else $error("pc wide");
endmodule
bind core_addr_unit core_addr_checker u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr));

/* File: verification/space_ref.sv */
`timescale 1ns/1ps
// reference picture of the ram and register spaces behind the core
module space_ref;
    logic [7:0] ram [256]; // data ram space
    logic [7:0] rsp [256]; // register space
    logic [7:0] flg = 8'h00; // flag register
    // read a byte; flags live at one fixed register address
    function automatic logic [7:0] rd(input logic s, input logic [7:0] a);
        if (s && a == 8'hF7) begin
            return flg;
        end
        return s ? rsp[a] : ram[a];
    endfunction
    // write a byte; the flag address ignores plain writes
    function automatic void wr(input logic s, input logic [7:0] a,
                               input logic [7:0] d);
        if (s && a != 8'hF7) begin
            rsp[a] = d;
        end else if (!s) begin
            ram[a] = d;
        end
    endfunction
    // both spaces start cleared
    initial begin
        foreach (ram[i]) begin
            ram[i] = 8'h00;
            rsp[i] = 8'h00;
        end
    end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
// register-level test of the operand addressing unit
module tb
    import core_addr_pkg::*;
();
    logic pclk = 1'b0; // bus clock
    logic presetn = 1'b0; // active-low reset
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [APB_DW-1:0] pwdata = '0;
    logic pready;
    logic [APB_DW-1:0] prdata;
    logic pslverr;
    int n_fail = 0; // mismatches
    int checks = 0; // comparisons
    logic [7:0] ea = 8'h00; // expected accumulator
    logic [7:0] ex = 8'h00; // expected index
    logic [7:0] esp = 8'h00; // expected stack pointer
    logic [15:0] epc = 16'h0000; // expected program counter
    logic [7:0] eop = 8'h00; // expected last opcode
    always #5 pclk = ~pclk;
    core_addr_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));
    space_ref sref ();
    ////////////////////////////////////////////////////////////////////////
    // one apb transfer, held until ready, then one idle cycle
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin // no answer
            n_fail++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // compare and count
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // read one offset, check data and error flag
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string nm);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(nm, r, exp);
        check(nm, {31'h0, e}, {31'h0, a > OFF_MEM_DATA || a[1:0] != 2'b00});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    // byte access through the memory window
    task automatic mem_wr(input logic s, input logic [7:0] a,
                          input logic [7:0] d);
        wr(OFF_MEM_ADDR, {23'h0, s, a});
        wr(OFF_MEM_DATA, {24'h0, d});
        sref.wr(s, a, d);
    endtask
    task automatic mem_chk(input logic s, input logic [7:0] a);
        wr(OFF_MEM_ADDR, {23'h0, s, a});
        rd_chk(OFF_MEM_DATA, {24'h0, sref.rd(s, a)}, "mem");
    endtask
    // expected alu result
    function automatic logic [7:0] f(input alu_op_e o, input logic [7:0] a,
                                     input logic [7:0] b);
        case (o)
            ALU_ADD: return 8'(a + b);
            ALU_AND: return a & b;
            ALU_OR: return a | b;
            default: return b;
        endcase
    endfunction
    task automatic chk_core();
        rd_chk(OFF_ACC, {24'h0, ea}, "acc");
        rd_chk(OFF_INDEX, {24'h0, ex}, "index");
        rd_chk(OFF_SP, {24'h0, esp}, "sp");
        rd_chk(OFF_PC, {16'h0, epc}, "pc");
    endtask
    // run one instruction and update the expected state
    task automatic exec(input addr_mode_e m, input alu_op_e o,
                        input target_e t, input logic s, input logic [7:0] b);
        logic [7:0] op = {m, o, t, s, 1'b0};
        logic [7:0] ad = (m == MODE_SRC_IDX) ? 8'(b + ex) : b;
        wr(OFF_INSTR, {16'h0, b, op});
        eop = op;
        case (m)
            MODE_SRC_IMM: begin
                case (t)
                    TGT_ACC: ea = f(o, ea, b);
                    TGT_INDEX: ex = f(o, ex, b);
                    TGT_SP: esp = f(o, esp, b);
                    default: begin
                        if (o == ALU_AND || o == ALU_OR) begin
                            sref.flg = f(o, sref.flg, b);
                        end
                    end
                endcase
            end
            MODE_DST_DIR: begin
                sref.wr(s, ad, f(o, sref.rd(s, ad), t == TGT_INDEX ? ex : ea));
            end
            default: begin
                if (t == TGT_INDEX) ex = f(o, ex, sref.rd(s, ad));
                else ea = f(o, ea, sref.rd(s, ad));
            end
        endcase
        epc = epc + PC_STEP;
        chk_core();
    endtask
    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk_core();
        mem_chk(1'b1, 8'hF7);
        for (int k = 0; k < 16; k++) begin
            mem_wr(1'b0, 8'(k), 8'(k * 13 + 1));
            mem_wr(1'b1, 8'(k), 8'(k * 29 + 3));
        end
        for (int o = 0; o < 4; o++) begin
            for (int t = 0; t < 4; t++) begin
                exec(MODE_SRC_IMM, alu_op_e'(o), target_e'(t), 1'b0,
                     8'(197 + o * 17 + t));
            end
        end
        mem_chk(1'b1, 8'hF7);
        exec(MODE_SRC_IMM, ALU_AND, TGT_FLAGS, 1'b0, 8'h3C);
        mem_chk(1'b1, 8'hF7);
        for (int m = 1; m < 4; m++) begin
            for (int o = 0; o < 4; o++) begin
                for (int i = 0; i < 4; i++) begin
                    exec(MODE_SRC_IMM, ALU_MOV, TGT_INDEX, 1'b0, 8'(o + 4));
                    exec(addr_mode_e'(m), alu_op_e'(o), target_e'(i % 2),
                         1'(i / 2), 8'(o * 2 + i));
                    mem_chk(1'(i / 2), 8'(o * 2 + i));
                end
            end
        end
        exec(MODE_SRC_IMM, ALU_MOV, TGT_INDEX, 1'b0, 8'hFE);
        exec(MODE_SRC_IDX, ALU_MOV, TGT_ACC, 1'b0, 8'h05);
        exec(MODE_SRC_DIR, ALU_MOV, TGT_INDEX, 1'b1, 8'hF7);
        exec(MODE_DST_DIR, ALU_MOV, TGT_ACC, 1'b1, 8'hF7);
        mem_chk(1'b1, 8'hF7);
        wr(OFF_ACC, 32'h0000_00A5);
        chk_core();
        rd_chk(OFF_STATUS, {16'h0, eop, 8'h00}, "status");
        rd_chk(8'h20, 32'h0, "unmapped");
        rd_chk(8'h06, 32'h0, "unaligned");
        report_and_stop();
    end
    // watchdog against a hung transfer
    initial begin
        #200us;
        n_fail++;
        report_and_stop();
    end
endmodule
